// ===== hdl/port_b_alternate_function_mux.sv
// Port B pin selector: routes each pad to its port or alternate function.
`timescale 1ns/1ps
`include "port_b_params.svh"
module port_b_alternate_function_mux (
  input wire CLOCK_IN,
  input wire RST_IN,
  input wire CHIP_RESET_IN,
  input wire [7:0] PAD_IN,
  input wire [7:0] DIRECTION_IN,
  input wire [7:0] OUTPUT_IN,
  input wire PULLUP_DISABLE_IN,
  input port_b_pkg::fuse_s FUSE_IN,
  input wire [7:0] CLOCK_DIV_IN,
  input port_b_pkg::timer1_s TIMER1_IN,
  input port_b_pkg::serial_s SERIAL_IN,
  input wire DEBUG_TX_LOW_IN,
  input wire EXT_IRQ_ZERO_ENABLE_IN,
  input wire [3:0] ANALOG_CHANNEL_IN,
  output port_b_pkg::pad_s PAD_OUT,
  output logic [7:0] DIRECTION_READ_OUT,
  output logic [7:0] OUTPUT_READ_OUT,
  output logic [7:0] INPUT_READ_OUT,
  output logic [7:0] PIN_CHANGE_SRC_OUT,
  output logic EXT_IRQ_ZERO_OUT,
  output logic SERIAL_UNIT_CLOCK_OUT,
  output logic SERIAL_IN_LINE_OUT,
  output logic DEBUG_RX_OUT,
  output logic RESET_REQUEST_OUT,
  output logic [2:0] ANALOG_SELECT_OUT
);

  port_b_pkg::state_s st_reg;
  port_b_pkg::state_s st_next;

  logic [7:0] dir_eff;
  logic [7:0] out_eff;
  logic div_tick;
  logic debug_mode;
  logic reset_mode;
  logic osc1_mode;
  logic osc2_mode;
  logic clkout_mode;
  logic sout_mode;
  logic two_wire_mode;
  logic route_on;
  logic wave;
  integer i;

  always_comb begin
    st_next = st_reg;
    // Pads are asynchronous to CLOCK_IN; the second stage is the only reader
    st_next.sync1 = PAD_IN;
    st_next.sync2 = st_reg.sync1;
    st_next.live = 1'b1;

    // Divider runs free so the clock pin keeps toggling through chip reset
    div_tick = (st_reg.div_cnt == CLOCK_DIV_IN);
    if (div_tick) begin
      st_next.div_cnt = `DIV_CNT_RST;
      st_next.div_clk = ~st_reg.div_clk;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + `DIV_CNT_STEP;
    end

    // Pad copies of the port registers are cleared while the chip is held in reset; read-back is not
    dir_eff = CHIP_RESET_IN ? `BYTE_ZERO : DIRECTION_IN;
    out_eff = CHIP_RESET_IN ? `BYTE_ZERO : OUTPUT_IN;

    debug_mode = FUSE_IN.debug_link_enable & ~FUSE_IN.lock_programmed;
    reset_mode = ~FUSE_IN.reset_pin_disable & ~debug_mode;
    osc1_mode = (FUSE_IN.clock_source != port_b_pkg::CLK_INTERNAL_RC);
    osc2_mode = (FUSE_IN.clock_source == port_b_pkg::CLK_CRYSTAL) |
                (FUSE_IN.clock_source == port_b_pkg::CLK_LOW_FREQ_XTAL);
    clkout_mode = FUSE_IN.clock_output & ~osc2_mode;
    sout_mode = SERIAL_IN.three_wire & SERIAL_IN.on_port_b;
    two_wire_mode = SERIAL_IN.two_wire & SERIAL_IN.on_port_b;
    route_on = 1'b0;
    wave = 1'b0;

    for (i = 0; i < 8; i = i + 1) begin
      st_next.pads.oe[i] = dir_eff[i];
      st_next.pads.out[i] = out_eff[i];
      st_next.pads.pull[i] = ~dir_eff[i] & out_eff[i] & ~PULLUP_DISABLE_IN;
      if ((i % 2) == 0) begin
        route_on = TIMER1_IN.control_reg_d[`ROUTE_A_LSB + i / 2] & TIMER1_IN.en_a;
        wave = TIMER1_IN.cmp_a;
      end else begin
        route_on = TIMER1_IN.control_reg_d[`ROUTE_B_LSB + i / 2] & TIMER1_IN.en_b;
        wave = TIMER1_IN.cmp_b;
      end
      // value only; the enable stays with the direction bit
      if (route_on & ~CHIP_RESET_IN) begin
        st_next.pads.out[i] = wave;
      end
    end

    // three-wire data output takes over the bit 1 value
    if (sout_mode) begin
      st_next.pads.out[`PIN_SOUT] = SERIAL_IN.shift_out;
    end
    // pull-up term above is left untouched in three-wire mode

    // two-wire lines only ever pull low
    if (two_wire_mode) begin
      st_next.pads.oe[`PIN_SIN] = (SERIAL_IN.shift_out | out_eff[`PIN_SIN]) &
                                  dir_eff[`PIN_SIN];
      st_next.pads.out[`PIN_SIN] = 1'b0;
      st_next.pads.oe[`PIN_SCLK] = (SERIAL_IN.clock_hold | out_eff[`PIN_SCLK]) &
                                   dir_eff[`PIN_SCLK];
      st_next.pads.out[`PIN_SCLK] = 1'b0;
    end

    // bit 4 is the clock input for every non-RC source
    if (osc1_mode) begin
      st_next.pads.oe[`PIN_OSC1] = 1'b0;
      st_next.pads.out[`PIN_OSC1] = 1'b0;
      st_next.pads.pull[`PIN_OSC1] = 1'b0;
    end

    // the crystal wins over the clock output on bit 5
    if (osc2_mode) begin
      st_next.pads.oe[`PIN_OSC2] = 1'b0;
      st_next.pads.out[`PIN_OSC2] = 1'b0;
      st_next.pads.pull[`PIN_OSC2] = 1'b0;
    end else if (clkout_mode) begin
      // forced drive, chip reset does not stop it
      st_next.pads.oe[`PIN_OSC2] = 1'b1;
      st_next.pads.out[`PIN_OSC2] = st_reg.div_clk;
      st_next.pads.pull[`PIN_OSC2] = 1'b0;
    end

    if (debug_mode) begin
      // open drain: only ever drives low, pull-up always on
      st_next.pads.oe[`PIN_RESET] = DEBUG_TX_LOW_IN;
      st_next.pads.out[`PIN_RESET] = 1'b0;
      st_next.pads.pull[`PIN_RESET] = 1'b1;
    end else if (reset_mode) begin
      // pin belongs to the reset circuit, never driven
      st_next.pads.oe[`PIN_RESET] = 1'b0;
      st_next.pads.out[`PIN_RESET] = 1'b0;
      st_next.pads.pull[`PIN_RESET] = 1'b1;
    end
    // with the reset disabled and no debug link, bit 7 keeps the port values above

    st_next.dir_rd = DIRECTION_IN;
    st_next.out_rd = OUTPUT_IN;
    st_next.in_rd = st_reg.sync2;
    // reset or debug pin reads as zero
    if (reset_mode | debug_mode) begin
      st_next.dir_rd[`PIN_RESET] = 1'b0;
      st_next.out_rd[`PIN_RESET] = 1'b0;
      st_next.in_rd[`PIN_RESET] = 1'b0;
    end
    // clock input pin reads as zero
    if (osc1_mode) begin
      st_next.dir_rd[`PIN_OSC1] = 1'b0;
      st_next.out_rd[`PIN_OSC1] = 1'b0;
      st_next.in_rd[`PIN_OSC1] = 1'b0;
    end

    // bit n feeds pin change source n plus eight
    st_next.pcint = st_reg.sync2;
    st_next.ext_irq = EXT_IRQ_ZERO_ENABLE_IN & st_reg.sync2[`PIN_IRQ];
    // serial clock and data input taps
    st_next.sclk = st_reg.sync2[`PIN_SCLK];
    st_next.sin = st_reg.sync2[`PIN_SIN];
    // Idle-high receive so a disabled debug link never looks like traffic
    st_next.dbg_rx = debug_mode ? st_reg.sync2[`PIN_RESET] : 1'b1;
    st_next.rst_req = reset_mode & ~st_reg.sync2[`PIN_RESET];

    // analog channel steering for bits 7..5
    st_next.ana_sel[2] = (ANALOG_CHANNEL_IN == `ANA_CH_BIT7);
    st_next.ana_sel[1] = (ANALOG_CHANNEL_IN == `ANA_CH_BIT6);
    st_next.ana_sel[0] = (ANALOG_CHANNEL_IN == `ANA_CH_BIT5);
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PAD_OUT = st_reg.pads;
  assign DIRECTION_READ_OUT = st_reg.dir_rd;
  assign OUTPUT_READ_OUT = st_reg.out_rd;
  assign INPUT_READ_OUT = st_reg.in_rd;
  assign PIN_CHANGE_SRC_OUT = st_reg.pcint;
  assign EXT_IRQ_ZERO_OUT = st_reg.ext_irq;
  assign SERIAL_UNIT_CLOCK_OUT = st_reg.sclk;
  assign SERIAL_IN_LINE_OUT = st_reg.sin;
  assign DEBUG_RX_OUT = st_reg.dbg_rx;
  assign RESET_REQUEST_OUT = st_reg.rst_req;
  assign ANALOG_SELECT_OUT = st_reg.ana_sel;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  // Outputs lag their causes by one edge; live masks the first edge after reset
  a_timer_dir_gate: assert property (
    st_reg.live && !$past(DIRECTION_IN[3]) |-> !PAD_OUT.oe[3])
    else $error("timer pin driven without direction bit");

  a_timer_route_wave: assert property (
    st_reg.live && $past(TIMER1_IN.control_reg_d[`ROUTE_B_LSB + 1] &
      TIMER1_IN.en_b & ~CHIP_RESET_IN)
    |-> PAD_OUT.out[3] == $past(TIMER1_IN.cmp_b))
    else $error("routed waveform missing on bit 3");

  a_bit7_plain_io: assert property (
    st_reg.live && $past(FUSE_IN.reset_pin_disable & ~debug_mode)
    |-> PAD_OUT.oe[7] == $past(dir_eff[7]) &&
      PAD_OUT.pull[7] == $past(~dir_eff[7] & out_eff[7] & ~PULLUP_DISABLE_IN))
    else $error("bit 7 not plain I/O with reset disabled");

  a_bit7_reset_only: assert property (
    st_reg.live && $past(reset_mode)
    |-> !PAD_OUT.oe[7] && RESET_REQUEST_OUT == !$past(st_reg.sync2[7]))
    else $error("reset pin drove or missed reset");

  a_bit7_reads_zero: assert property (
    st_reg.live && $past(reset_mode | debug_mode)
    |-> !DIRECTION_READ_OUT[7] && !OUTPUT_READ_OUT[7] && !INPUT_READ_OUT[7])
    else $error("reset pin read back nonzero");

  a_debug_open_drain: assert property (
    st_reg.live && $past(debug_mode) |-> PAD_OUT.pull[7] && !PAD_OUT.out[7] &&
      PAD_OUT.oe[7] == $past(DEBUG_TX_LOW_IN))
    else $error("debug pin not open drain");

  a_clkout_forced: assert property (
    st_reg.live && $past(clkout_mode) && clkout_mode
    && $changed(st_reg.div_clk) |=> PAD_OUT.oe[5] && $changed(PAD_OUT.out[5]))
    else $error("divided clock not on bit 5");

  a_clkout_in_reset: assert property (
    st_reg.live && $past(CHIP_RESET_IN & clkout_mode)
    |-> PAD_OUT.oe[5] && PAD_OUT.out[5] == $past(st_reg.div_clk))
    else $error("clock output stopped in chip reset");

  a_osc2_no_io: assert property (
    st_reg.live && $past(osc2_mode) |-> !PAD_OUT.oe[5] && !PAD_OUT.pull[5])
    else $error("crystal pin used as I/O");

  a_osc1_no_io: assert property (
    st_reg.live && $past(osc1_mode) |-> !PAD_OUT.oe[4] && !PAD_OUT.pull[4])
    else $error("clock input pin used as I/O");

  a_osc1_reads_zero: assert property (
    st_reg.live && $past(osc1_mode)
    |-> (DIRECTION_READ_OUT[4] | OUTPUT_READ_OUT[4] | INPUT_READ_OUT[4]) == 1'b0)
    else $error("clock pin read back nonzero");

  a_serial_out_value: assert property (
    st_reg.live && $past(sout_mode) |-> PAD_OUT.out[1] == $past(SERIAL_IN.shift_out)
      && PAD_OUT.oe[1] == $past(dir_eff[1]))
    else $error("serial data out not on bit 1");

  a_serial_pullup: assert property (
    st_reg.live && $past(sout_mode & ~dir_eff[1] & out_eff[1] & ~PULLUP_DISABLE_IN)
    |-> PAD_OUT.pull[1])
    else $error("bit 1 pull-up lost in three-wire mode");

  a_pin_change_map: assert property (
    PIN_CHANGE_SRC_OUT == $past(st_reg.sync2) && st_reg.sync2 == $past(st_reg.sync1))
    else $error("pin change sources misrouted");

  a_ext_irq_tap: assert property (
    st_reg.live && $past(EXT_IRQ_ZERO_ENABLE_IN) |-> EXT_IRQ_ZERO_OUT == $past(st_reg.sync2[6]))
    else $error("bit 6 not on external interrupt");

  a_serial_taps: assert property (
    SERIAL_UNIT_CLOCK_OUT == $past(st_reg.sync2[2]) && SERIAL_IN_LINE_OUT == $past(st_reg.sync2[0]))
    else $error("serial inputs misrouted");

  a_analog_select: assert property (
    st_reg.live && $past(ANALOG_CHANNEL_IN) == `ANA_CH_BIT7 |-> ANALOG_SELECT_OUT == 3'h4)
    else $error("channel ten not on bit 7");

  a_plain_pin: assert property (
    st_reg.live |-> PAD_OUT.oe[3] == $past(dir_eff[3]) && PAD_OUT.pull[3] ==
      $past(~dir_eff[3] & out_eff[3] & ~PULLUP_DISABLE_IN))
    else $error("unclaimed pin ignores port settings");

endmodule : port_b_alternate_function_mux

// ===== hdl/port_b_params.svh
// Constants for the port B alternate function selector.
`ifndef PORT_B_PARAMS_SVH
`define PORT_B_PARAMS_SVH
`define PIN_RESET 7
`define PIN_IRQ 6
`define PIN_OSC2 5
`define PIN_OSC1 4
`define PIN_SCLK 2
`define PIN_SOUT 1
`define PIN_SIN 0
`define ROUTE_A_LSB 0
`define ROUTE_B_LSB 4
`define ANA_CH_BIT7 4'hA
`define ANA_CH_BIT6 4'h9
`define ANA_CH_BIT5 4'h8
`define DIV_CNT_RST 8'h00
`define DIV_CNT_STEP 8'h01
`define BYTE_ZERO 8'h00
`endif

// ===== hdl/port_b_pkg.sv
// Types shared by the port B alternate function selector.
package port_b_pkg;
  typedef enum logic [1:0] {
    CLK_INTERNAL_RC = 2'b00,
    CLK_EXTERNAL = 2'b01,
    CLK_CRYSTAL = 2'b10,
    CLK_LOW_FREQ_XTAL = 2'b11
  } clk_src_e;
  typedef struct packed {
    logic reset_pin_disable;
    logic debug_link_enable;
    logic lock_programmed;
    logic clock_output;
    clk_src_e clock_source;
  } fuse_s;
  typedef struct packed {
    logic [7:0] control_reg_d;
    logic cmp_a;
    logic cmp_b;
    logic en_a;
    logic en_b;
  } timer1_s;
  typedef struct packed {
    logic three_wire;
    logic two_wire;
    logic on_port_b;
    logic shift_out;
    logic clock_hold;
  } serial_s;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pad_s;
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    pad_s pads;
    logic [7:0] dir_rd;
    logic [7:0] out_rd;
    logic [7:0] in_rd;
    logic [7:0] pcint;
    logic [7:0] div_cnt;
    logic div_clk;
    logic ext_irq;
    logic sclk;
    logic sin;
    logic dbg_rx;
    logic rst_req;
    logic [2:0] ana_sel;
    logic live;
  } state_s;
endpackage : port_b_pkg

// ===== tb/port_b_board_model.sv
// Board circuitry model seen by the port B pads.
`timescale 1ns/1ps
module port_b_board_model (
  input wire clk_in,
  input port_b_pkg::pad_s pad_in,
  input wire [7:0] drive_en_in,
  input wire [7:0] drive_val_in,
  output logic [7:0] level_out
);
  logic [7:0] last;
  initial last = 8'h00;
  // wire-AND, pull-up level
  // A floating undriven pad flips each cycle so no stale value looks valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_in.oe[i] && drive_en_in[i]) level_out[i] = pad_in.out[i] & drive_val_in[i];
      else if (pad_in.oe[i]) level_out[i] = pad_in.out[i];
      else if (drive_en_in[i]) level_out[i] = drive_val_in[i];
      else if (pad_in.pull[i]) level_out[i] = 1'b1;
      else level_out[i] = ~last[i];
    end
  end
  always @(posedge clk_in) last <= level_out;
endmodule : port_b_board_model

// ===== tb/port_b_alternate_function_mux_tb_top.sv
// Self-checking bench for the port B alternate function selector.
`timescale 1ns/1ps
module port_b_alternate_function_mux_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chip_rst = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] outb = 8'h00;
  logic pud = 1'b0;
  logic dbg_tx = 1'b0;
  logic irq_en = 1'b0;
  logic [3:0] ana = 4'h0;
  logic [7:0] bd_en = 8'hFF;
  logic [7:0] bd_val = 8'h00;
  logic [7:0] pads;
  port_b_pkg::fuse_s fuse = '{1'b1, 1'b0, 1'b0, 1'b0, port_b_pkg::CLK_INTERNAL_RC};
  port_b_pkg::timer1_s tmr = '0;
  port_b_pkg::serial_s ser = '0;
  port_b_pkg::pad_s pad_o;
  logic [7:0] dir_rd, out_rd, in_rd, pcs;
  logic irq_o, sclk_o, sin_o, dbg_rx, rst_req;
  logic [2:0] ana_sel;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  port_b_alternate_function_mux i_dut (.CLOCK_IN(clk), .RST_IN(rst), .CHIP_RESET_IN(chip_rst),
    .PAD_IN(pads), .DIRECTION_IN(dir), .OUTPUT_IN(outb), .PULLUP_DISABLE_IN(pud),
    .FUSE_IN(fuse), .CLOCK_DIV_IN(8'h01), .TIMER1_IN(tmr), .SERIAL_IN(ser),
    .DEBUG_TX_LOW_IN(dbg_tx), .EXT_IRQ_ZERO_ENABLE_IN(irq_en), .ANALOG_CHANNEL_IN(ana),
    .PAD_OUT(pad_o), .DIRECTION_READ_OUT(dir_rd), .OUTPUT_READ_OUT(out_rd),
    .INPUT_READ_OUT(in_rd), .PIN_CHANGE_SRC_OUT(pcs), .EXT_IRQ_ZERO_OUT(irq_o),
    .SERIAL_UNIT_CLOCK_OUT(sclk_o), .SERIAL_IN_LINE_OUT(sin_o), .DEBUG_RX_OUT(dbg_rx),
    .RESET_REQUEST_OUT(rst_req), .ANALOG_SELECT_OUT(ana_sel));
  port_b_board_model i_board (.clk_in(clk), .pad_in(pad_o), .drive_en_in(bd_en),
    .drive_val_in(bd_val), .level_out(pads));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  task t_timer;
    tmr = '{8'h28, 1'b1, 1'b1, 1'b1, 1'b1};
    step(3);
    chk("oe no dir", 8'h00, pad_o.oe & 8'h48);
    dir = 8'h48;
    outb = 8'h00;
    bd_en = 8'hB7;
    step(3);
    chk("timer oe", 8'h48, pad_o.oe & 8'h48);
    chk("timer out", 8'h48, pad_o.out & 8'h48);
    tmr.control_reg_d = 8'h00;
    step(3);
    chk("port out", 8'h00, pad_o.out & 8'h48);
    dir = 8'h00;
    bd_en = 8'hFF;
    $display("test timer done");
  endtask : t_timer
  task t_reset_pin;
    dir = 8'h80;
    outb = 8'h80;
    step(3);
    chk("io rd", 8'h80, dir_rd & out_rd & 8'h80);
    fuse.reset_pin_disable = 1'b0;
    bd_val = 8'h00;
    step(4);
    chk("rst rd", 8'h00, (dir_rd | out_rd | in_rd) & 8'h80);
    chk("rst pad", 8'h80, {pad_o.pull[7], pad_o.oe[7], 6'h00});
    chk("rst req", 8'h01, {7'h00, rst_req});
    fuse.debug_link_enable = 1'b1;
    bd_en = 8'h7F;
    dbg_tx = 1'b1;
    step(4);
    chk("dbg low", 8'h00, {7'h00, pads[7]});
    dbg_tx = 1'b0;
    step(4);
    chk("dbg pull", 8'h81, {pad_o.pull[7], 6'h00, dbg_rx});
    fuse = '{1'b1, 1'b0, 1'b0, 1'b0, port_b_pkg::CLK_INTERNAL_RC};
    bd_en = 8'hFF;
    dir = 8'h00;
    outb = 8'h00;
    $display("test reset pin done");
  endtask : t_reset_pin
  task t_clock;
    logic a;
    fuse.clock_output = 1'b1;
    step(3);
    a = pad_o.out[5];
    chk("divided_clock_out oe", 8'h20, pad_o.oe & 8'h20);
    step(2);
    chk("divided_clock_out tog", 8'h01, {7'h00, a ^ pad_o.out[5]});
    chip_rst = 1'b1;
    step(1);
    a = pad_o.out[5];
    step(2);
    chk("divided_clock_out rst", 8'h21, {2'h0, pad_o.oe[5], 4'h0, a ^ pad_o.out[5]});
    chip_rst = 1'b0;
    fuse.clock_source = port_b_pkg::CLK_CRYSTAL;
    dir = 8'h30;
    outb = 8'h30;
    step(3);
    chk("xtal oe", 8'h00, pad_o.oe & 8'h30);
    chk("xtal rd", 8'h00, (dir_rd | out_rd | in_rd) & 8'h10);
    fuse.clock_source = port_b_pkg::CLK_EXTERNAL;
    step(3);
    chk("ext rd", 8'h00, (dir_rd | out_rd | pad_o.oe) & 8'h10);
    fuse = '{1'b1, 1'b0, 1'b0, 1'b0, port_b_pkg::CLK_INTERNAL_RC};
    dir = 8'h00;
    outb = 8'h00;
    $display("test clock done");
  endtask : t_clock
  task t_inputs;
    bd_val = 8'h45;
    irq_en = 1'b1;
    step(4);
    chk("pcint", 8'h45, pcs);
    chk("in rd", 8'h45, in_rd);
    chk("taps", 8'h07, {5'h00, irq_o, sclk_o, sin_o});
    bd_val = 8'hBA;
    step(4);
    chk("pcint2", 8'hBA, pcs);
    chk("taps2", 8'h00, {5'h00, irq_o, sclk_o, sin_o});
    ana = 4'hA;
    step(2);
    chk("ana10", 8'h04, {5'h00, ana_sel});
    ana = 4'h8;
    step(2);
    chk("ana8", 8'h01, {5'h00, ana_sel});
    irq_en = 1'b0;
    $display("test inputs done");
  endtask : t_inputs
  task t_serial;
    ser = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    dir = 8'h02;
    outb = 8'h00;
    bd_en = 8'hFD;
    step(3);
    chk("do drive", 8'h02, pad_o.oe & pad_o.out & 8'h02);
    dir = 8'h00;
    outb = 8'h02;
    step(3);
    chk("do pull", 8'h02, pad_o.pull & ~pad_o.oe & 8'h02);
    ser = '0;
    bd_en = 8'hFF;
    outb = 8'h00;
    $display("test serial done");
  endtask : t_serial
  task t_two_wire;
    ser = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    dir = 8'h05;
    outb = 8'h00;
    step(3);
    chk("tw idle", 8'h00, pad_o.oe & 8'h05);
    ser.shift_out = 1'b1;
    ser.clock_hold = 1'b1;
    step(3);
    chk("tw low", 8'h05, pad_o.oe & ~pad_o.out & 8'h05);
    ser = '0;
    dir = 8'h30;
    outb = 8'hFF;
    pud = 1'b1;
    fuse.clock_source = port_b_pkg::CLK_LOW_FREQ_XTAL;
    step(3);
    chk("pud off", 8'h00, pad_o.pull);
    chk("lf xtal", 8'h00, pad_o.oe & 8'h30);
    fuse.clock_source = port_b_pkg::CLK_INTERNAL_RC;
    pud = 1'b0;
    dir = 8'h00;
    outb = 8'h00;
    $display("test two wire done");
  endtask : t_two_wire
  initial begin
    step(16);
    rst = 1'b0;
    step(3);
    t_timer();
    t_reset_pin();
    t_clock();
    t_inputs();
    t_serial();
    t_two_wire();
    results();
  end
endmodule : port_b_alternate_function_mux_tb_top
